// ===== bench/flash_array_model.sv
`timescale 1ns/1ns
module flash_array_model #(
	parameter int FAST = 2,
	parameter int SLOW = 9
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// operation port
	input wire logic flash_op_start,
	output logic flash_busy
);
	logic [7:0] left;
	logic slow;
	// alternate short and long operations so both answer speeds are seen
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			left <= 8'h0;
			slow <= 1'b0;
		end else if (flash_op_start) begin
			left <= slow ? 8'(SLOW) : 8'(FAST);
			slow <= !slow;
		end else if (left != 8'h0) begin
			left <= left - 8'h1;
		end
	end
	// busy already in the start cycle, so the writer never sees a gap
	assign flash_busy = flash_op_start | (left != 8'h0);
endmodule // flash_array_model

// ===== bench/testbench.sv
`timescale 1ns/1ns
module testbench;
	import flash_writer_pkg::*;
	logic clk_sys, rst, ce, hs_request, hs_ready, hs_acknowledge, flash_op_start, flash_word_write, flash_busy;
	handshake_word_t hs_word;
	flash_op_t flash_op;
	logic [17:0] flash_page, prog_page;
	logic [1:0] flash_word_index;
	logic [15:0] flash_word_data;
	logic [15:0] mem [4];
	flash_op_t ops [$];
	int fail_count = 0;
	int checked = 0;
	// a four-word page keeps every flush short
	parallel_flash_page_writer #(.PAGE_LOG2(2), .REGION_LOG2(1)) dut (.clk_sys, .rst, .ce, .hs_request, .hs_word,
		.hs_ready, .hs_acknowledge, .flash_op, .flash_op_start, .flash_page, .flash_word_index, .flash_word_data,
		.flash_word_write, .flash_busy);
	flash_array_model partner (.clk_sys, .rst, .flash_op_start, .flash_busy);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (flash_op_start) begin
			ops.push_back(flash_op);
			if (flash_op == FOP_PROGRAM_PAGE) prog_page = flash_page;
		end
		if (flash_word_write) mem[flash_word_index] = flash_word_data;
	end
	////////////////////////////////////////////////////////////////
	task complete_run;
		$display("checks %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic hs(input logic [3:0] m, input logic [15:0] d);
		int n = 0;
		hs_word <= {m, d};
		hs_request <= 1'b1;
		do begin @(posedge clk_sys); n++; end while (hs_acknowledge !== 1'b1 && n < 3000);
		hs_request <= 1'b0;
		do begin @(posedge clk_sys); n++; end while (hs_ready !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			fail_count++;
			$display("mismatch at %0t: handshake timed out", $time);
			complete_run();
		end
	endtask
	task automatic wait_idle;
		int n = 0;
		do begin @(posedge clk_sys); n++; end while ((ops.size() == 0 || ops[$] != FOP_ERASE_ALL || flash_busy) && n < 500);
		if (n >= 500) begin
			fail_count++;
			$display("mismatch at %0t: full erase timed out", $time);
			complete_run();
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_kinds;
		flash_op_t e [$];
		for (int k = 0; k < 4; k++) begin
			hs(MODE_COMMAND_ENTRY, CMD_WRITE_PAGE + 16'(k));
			hs(MODE_ADDRESS_LOW, 16'h0008);
			hs(MODE_ADDRESS_HIGH, 16'h0000);
			hs(MODE_DATA, 16'ha000 + 16'(k));
			ops.delete();
			hs(MODE_COMMAND_ENTRY, CMD_FULL_ERASE);
			wait_idle();
			e = {FOP_PROGRAM_PAGE};
			if (k >= 2) e.push_front(FOP_ERASE_PAGE);
			if (k % 2 == 1) e.push_back(FOP_LOCK_REGION);
			e.push_back(FOP_ERASE_ALL);
			chk(ops.size(), e.size());
			foreach (e[i]) chk(ops[i], e[i]);
			chk(mem[0], 16'ha000 + 16'(k));
			chk(prog_page, 18'h00002);
		end
		$display("test command kinds done");
	endtask
	task t_cross;
		hs(MODE_COMMAND_ENTRY, CMD_WRITE_PAGE);
		hs(MODE_ADDRESS_LOW, 16'h0007);
		hs(MODE_ADDRESS_HIGH, 16'h0001);
		hs(MODE_DATA, 16'h1111);
		ops.delete();
		hs(MODE_DATA, 16'h2222);
		chk(ops.size(), 1);
		chk(ops[0], FOP_PROGRAM_PAGE);
		chk(prog_page, 18'h04001);
		chk(mem[3], 16'h1111);
		hs(MODE_COMMAND_ENTRY, CMD_FULL_ERASE);
		wait_idle();
		chk(prog_page, 18'h04002);
		chk(mem[0], 16'h2222);
		$display("test page crossing done");
	endtask
	task automatic t_region;
		ops.delete();
		hs(MODE_COMMAND_ENTRY, CMD_WRITE_PAGE);
		hs(MODE_ADDRESS_LOW, 16'h0010);
		hs(MODE_ADDRESS_HIGH, 16'h0000);
		hs(MODE_DATA, 16'h3333);
		hs(MODE_COMMAND_ENTRY, CMD_WRITE_PAGE_LOCK);
		chk(ops.size(), 1);
		chk(ops[0], FOP_PROGRAM_PAGE);
		chk(prog_page, 18'h00004);
		hs(MODE_ADDRESS_LOW, 16'h0014);
		hs(MODE_ADDRESS_HIGH, 16'h0000);
		hs(MODE_DATA, 16'h4444);
		ops.delete();
		hs(MODE_COMMAND_ENTRY, CMD_WRITE_PAGE);
		chk(ops.size(), 2);
		chk(ops[0], FOP_PROGRAM_PAGE);
		chk(ops[1], FOP_LOCK_REGION);
		chk(prog_page, 18'h00005);
		chk(mem[0], 16'h4444);
		$display("test region lock done");
	endtask
	task automatic t_freeze;
		ce <= 1'b0;
		hs_word <= {MODE_DATA, 16'h5555};
		hs_request <= 1'b1;
		repeat (10) @(posedge clk_sys);
		chk(hs_acknowledge, 1'b0);
		chk(hs_ready, 1'b1);
		ce <= 1'b1;
		hs_request <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk(hs_ready, 1'b1);
		$display("test clock enable done");
	endtask
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		hs_request = 1'b0;
		hs_word = '0;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_kinds();
		t_cross();
		t_region();
		t_freeze();
		complete_run();
	end
endmodule // testbench

// ===== bench/writer_props.sv
`timescale 1ns/1ns
module writer_props
	import flash_writer_pkg::*;
#(
	parameter int WORD_ADDR_BITS = WORD_ADDR_W,
	parameter int PAGE_LOG2 = PAGE_WORDS_LOG2,
	parameter int REGION_LOG2 = REGION_PAGES_LOG2
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// handshake
	input wire logic hs_request,
	input wire flash_writer_pkg::handshake_word_t hs_word,
	input wire logic hs_ready,
	input wire logic hs_acknowledge,
	// flash port
	input wire flash_writer_pkg::flash_op_t flash_op,
	input wire logic flash_op_start,
	input wire logic [WORD_ADDR_BITS-PAGE_LOG2-1:0] flash_page,
	input wire logic [PAGE_LOG2-1:0] flash_word_index,
	input wire logic [15:0] flash_word_data,
	input wire logic flash_word_write,
	input wire logic flash_busy
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [15:0] words;
	flash_op_t last_op;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			words <= 16'h0;
		end else if (flash_op_start) begin
			words <= 16'h0;
		end else if (flash_word_write) begin
			words <= words + 16'h1;
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			last_op <= FOP_NONE;
		end else if (flash_op_start) begin
			last_op <= flash_op;
		end
	end
	start_pulse_a: assert property (flash_op_start |=> !flash_op_start) else $error("start not one cycle");
	start_op_a: assert property (flash_op_start |-> flash_op != FOP_NONE) else $error("start without op");
	// the last word write shares its cycle with the program start
	word_count_a: assert property (flash_op_start && flash_op == FOP_PROGRAM_PAGE |->
		words + 16'(flash_word_write) == 16'(1 << PAGE_LOG2))
		else $error("program without full page");
	word_order_a: assert property (flash_word_write |-> flash_word_index == words[PAGE_LOG2-1:0])
		else $error("word index out of order");
	lock_last_a: assert property (flash_op_start && flash_op == FOP_LOCK_REGION |-> last_op == FOP_PROGRAM_PAGE)
		else $error("lock not after program");
	ack_idle_a: assert property ($rose(hs_acknowledge) |-> !flash_busy) else $error("ack while flash busy");
	ack_drop_a: assert property ($fell(hs_request) |-> ##[1:4] !hs_acknowledge) else $error("ack stuck");
	page_hold_a: assert property (flash_busy && !flash_op_start |-> $stable(flash_page))
		else $error("page moved while busy");
	cover property (flash_op_start && flash_op == FOP_ERASE_PAGE);
	cover property (flash_op_start && flash_op == FOP_LOCK_REGION);
	cover property (flash_op_start && flash_op == FOP_ERASE_ALL);
endmodule // writer_props
bind parallel_flash_page_writer writer_props #(.WORD_ADDR_BITS(WORD_ADDR_BITS), .PAGE_LOG2(PAGE_LOG2),
	.REGION_LOG2(REGION_LOG2)) props (.clk_sys(clk_sys), .rst(rst), .ce(ce), .hs_request(hs_request),
	.hs_word(hs_word), .hs_ready(hs_ready), .hs_acknowledge(hs_acknowledge), .flash_op(flash_op),
	.flash_op_start(flash_op_start), .flash_page(flash_page), .flash_word_index(flash_word_index),
	.flash_word_data(flash_word_data), .flash_word_write(flash_word_write), .flash_busy(flash_busy));

// ===== src/flash_writer_pkg.sv
package flash_writer_pkg;

	// mode codes carried on the handshake with each data word
	localparam logic [3:0] MODE_COMMAND_ENTRY = 4'h1;
	localparam logic [3:0] MODE_ADDRESS_LOW = 4'h2;
	localparam logic [3:0] MODE_ADDRESS_HIGH = 4'h3;
	localparam logic [3:0] MODE_DATA = 4'h4;

	// command codes, arbitrary values
	localparam logic [15:0] CMD_WRITE_PAGE = 16'h0011;
	localparam logic [15:0] CMD_WRITE_PAGE_LOCK = 16'h0012;
	localparam logic [15:0] CMD_ERASE_THEN_WRITE = 16'h0013;
	localparam logic [15:0] CMD_ERASE_THEN_WRITE_LOCK = 16'h0014;
	localparam logic [15:0] CMD_FULL_ERASE = 16'h0020;

	// geometry defaults
	localparam int WORD_ADDR_W = 20;
	localparam int PAGE_WORDS_LOG2 = 8;
	localparam int REGION_PAGES_LOG2 = 4;
	localparam int ADDR_LOW_W = 16;

	// flash operations issued to the array port
	typedef enum logic [2:0] {
		FOP_NONE,
		FOP_ERASE_PAGE,
		FOP_PROGRAM_PAGE,
		FOP_LOCK_REGION,
		FOP_ERASE_ALL
	} flash_op_t;

	typedef struct packed {
		logic [3:0] mode;
		logic [15:0] data;
	} handshake_word_t;

	typedef enum logic [1:0] {
		WRITE_PLAIN,
		WRITE_LOCK,
		WRITE_ERASE,
		WRITE_ERASE_LOCK
	} write_kind_t;

endpackage

// ===== src/page_load_buffer.sv
`timescale 1ns/1ns
module page_load_buffer #(
	parameter int DEPTH_LOG2 = 8
) (
	// clocking
	input wire logic clk_sys,
	input wire logic ce,
	// fill side
	input wire logic wr_en,
	input wire logic [DEPTH_LOG2-1:0] wr_index,
	input wire logic [15:0] wr_data,
	// drain side
	input wire logic [DEPTH_LOG2-1:0] rd_index,
	output logic [15:0] rd_data
);
	// holds exactly one page; unwritten words keep stale data, and the parent streams every word of the page regardless
	logic [15:0] mem [0:(1<<DEPTH_LOG2)-1];

	always_ff @(posedge clk_sys) begin
		if (ce && wr_en) begin
			mem[wr_index] <= wr_data;
		end
		if (ce) begin
			rd_data <= mem[rd_index];
		end
	end
endmodule // page_load_buffer

// ===== src/parallel_flash_page_writer.sv
`timescale 1ns/1ns
module parallel_flash_page_writer
	import flash_writer_pkg::*;
#(
	parameter int WORD_ADDR_BITS = WORD_ADDR_W,
	parameter int PAGE_LOG2 = PAGE_WORDS_LOG2,
	parameter int REGION_LOG2 = REGION_PAGES_LOG2
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// programmer handshake (pins)
	input wire logic hs_request,
	input wire flash_writer_pkg::handshake_word_t hs_word,
	output logic hs_ready,
	output logic hs_acknowledge,
	// flash array port
	output flash_writer_pkg::flash_op_t flash_op,
	output logic flash_op_start,
	output logic [WORD_ADDR_BITS-PAGE_LOG2-1:0] flash_page,
	output logic [PAGE_LOG2-1:0] flash_word_index,
	output logic [15:0] flash_word_data,
	output logic flash_word_write,
	input wire logic flash_busy
);
	import flash_writer_pkg::*;

	localparam int PAGE_W = WORD_ADDR_BITS - PAGE_LOG2;
	localparam int WORDS = 1 << PAGE_LOG2;

	typedef enum {
		ST_IDLE,
		ST_ACK,
		ST_FLUSH_ERASE,
		ST_FLUSH_PROGRAM,
		ST_FLUSH_STREAM,
		ST_FLUSH_WAIT,
		ST_FLUSH_LOCK,
		ST_FULL_ERASE,
		ST_OP_WAIT
	} state_t;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic req_meta;
	logic req_sync;
	handshake_word_t word_meta;
	handshake_word_t word_sync;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			req_meta <= 1'b0;
			req_sync <= 1'b0;
			word_meta <= '0;
			word_sync <= '0;
		end else if (ce) begin
			req_meta <= hs_request;
			req_sync <= req_meta;
			word_meta <= hs_word;
			word_sync <= word_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state

	state_t state;
	state_t after_op;
	write_kind_t kind;
	logic [WORD_ADDR_BITS-1:0] write_addr;
	logic [PAGE_W-1:0] buf_page;
	logic buf_dirty;
	logic [PAGE_LOG2-1:0] stream_idx;
	logic stream_last;
	handshake_word_t held;
	logic held_pending;

	logic [PAGE_W-1:0] addr_page;
	logic need_flush;
	logic is_cmd;
	logic is_data;
	logic buf_wr;
	logic [15:0] buf_rd;

	assign addr_page = write_addr[WORD_ADDR_BITS-1:PAGE_LOG2];
	assign is_cmd = held.mode == MODE_COMMAND_ENTRY;
	assign is_data = held.mode == MODE_DATA;
	// a data word to another page, or any new command, empties the buffer first
	assign need_flush = buf_dirty && (is_cmd || (is_data && addr_page != buf_page));
	assign buf_wr = state == ST_IDLE && held_pending && is_data && !need_flush;

	page_load_buffer #(
		.DEPTH_LOG2(PAGE_LOG2)
	) u_buffer (
		.clk_sys(clk_sys),
		.ce(ce),
		.wr_en(buf_wr),
		.wr_index(write_addr[PAGE_LOG2-1:0]),
		.wr_data(held.data),
		.rd_index(stream_idx),
		.rd_data(buf_rd)
	);

	////////////////////////////////////////////////////////////////////////
	// handshake capture: mode and data are latched as one word

	logic req_seen;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			held <= '0;
			held_pending <= 1'b0;
			req_seen <= 1'b0;
		end else if (ce) begin
			if (req_sync && !req_seen && !held_pending) begin
				held <= word_sync;
				held_pending <= 1'b1;
				req_seen <= 1'b1;
			end else if (state == ST_ACK) begin
				held_pending <= 1'b0;
			end
			// the acknowledge stays up until the programmer drops its request
			if (!req_sync && !held_pending) begin
				req_seen <= 1'b0;
			end
		end
	end

	assign hs_ready = !held_pending && !req_seen;
	assign hs_acknowledge = req_seen && !held_pending;

	////////////////////////////////////////////////////////////////////////
	// sequencer

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			after_op <= ST_IDLE;
			kind <= WRITE_PLAIN;
			write_addr <= '0;
			buf_page <= '0;
			buf_dirty <= 1'b0;
			stream_idx <= '0;
			stream_last <= 1'b0;
			flash_op <= FOP_NONE;
			flash_op_start <= 1'b0;
			flash_page <= '0;
			flash_word_index <= '0;
			flash_word_data <= '0;
			flash_word_write <= 1'b0;
		end else if (ce) begin
			flash_op_start <= 1'b0;
			flash_word_write <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (held_pending) begin
						if (need_flush) begin
							flash_page <= buf_page;
							// erase kinds clear the page before programming it
							if (kind == WRITE_ERASE || kind == WRITE_ERASE_LOCK) begin
								state <= ST_FLUSH_ERASE;
							end else begin
								state <= ST_FLUSH_PROGRAM;
							end
						end else begin
							state <= ST_ACK;
							case (held.mode)
								MODE_COMMAND_ENTRY: begin
									if (held.data == CMD_WRITE_PAGE_LOCK) kind <= WRITE_LOCK;
									else if (held.data == CMD_ERASE_THEN_WRITE) kind <= WRITE_ERASE;
									else if (held.data == CMD_ERASE_THEN_WRITE_LOCK) kind <= WRITE_ERASE_LOCK;
									else kind <= WRITE_PLAIN;
									if (held.data == CMD_FULL_ERASE) state <= ST_FULL_ERASE;
								end
								MODE_ADDRESS_LOW: begin
									write_addr[ADDR_LOW_W-1:0] <= held.data;
								end
								MODE_ADDRESS_HIGH: begin
									write_addr[WORD_ADDR_BITS-1:ADDR_LOW_W] <=
										held.data[WORD_ADDR_BITS-ADDR_LOW_W-1:0];
								end
								MODE_DATA: begin
									buf_page <= addr_page;
									buf_dirty <= 1'b1;
									write_addr <= write_addr + 1'b1;
								end
								default: begin
								end
							endcase
						end
					end
				end
				ST_ACK: begin
					state <= ST_IDLE;
				end
				ST_FLUSH_ERASE: begin
					flash_op <= FOP_ERASE_PAGE;
					flash_op_start <= 1'b1;
					after_op <= ST_FLUSH_PROGRAM;
					state <= ST_OP_WAIT;
				end
				ST_FLUSH_PROGRAM: begin
					stream_idx <= '0;
					stream_last <= 1'b0;
					state <= ST_FLUSH_STREAM;
				end
				ST_FLUSH_STREAM: begin
					// buffer read has one cycle latency, so write lags the index by one
					if (stream_last || stream_idx != '0) begin
						flash_word_write <= 1'b1;
						flash_word_index <= stream_idx - 1'b1;
						flash_word_data <= buf_rd;
					end
					if (stream_last) begin
						flash_op <= FOP_PROGRAM_PAGE;
						flash_op_start <= 1'b1;
						after_op <= (kind == WRITE_LOCK || kind == WRITE_ERASE_LOCK) ? ST_FLUSH_LOCK : ST_IDLE;
						state <= ST_OP_WAIT;
					end else begin
						stream_idx <= stream_idx + 1'b1;
						stream_last <= stream_idx == PAGE_LOG2'(WORDS - 1);
					end
				end
				ST_FLUSH_LOCK: begin
					// lock follows the end of programming; the programmer picks which page carries it
					flash_op <= FOP_LOCK_REGION;
					flash_op_start <= 1'b1;
					after_op <= ST_IDLE;
					state <= ST_OP_WAIT;
				end
				ST_FULL_ERASE: begin
					flash_op <= FOP_ERASE_ALL;
					flash_op_start <= 1'b1;
					// the command word is still held; retire it through the ack state or it would run again
					after_op <= ST_ACK;
					state <= ST_OP_WAIT;
				end
				ST_OP_WAIT: begin
					if (!flash_op_start && !flash_busy) begin
						state <= after_op;
						if (after_op == ST_IDLE || after_op == ST_ACK) begin
							buf_dirty <= 1'b0;
							flash_op <= FOP_NONE;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// region of the page being locked is flash_page >> REGION_LOG2; the array port derives it
	logic unused_region;
	assign unused_region = REGION_LOG2 > 0;
endmodule // parallel_flash_page_writer
